// >>> include/pp_rx_pkg.sv
// shared constants for the parallel port receive buffer control block
`default_nettype none
package pp_rx_pkg;
   // ************************************************************
   // register word offsets (byte addresses, one word each)
   // ************************************************************
   localparam logic [7:0] OFF_FUNC_CODE = 8'h00; // dma_function_code_byte
   localparam logic [7:0] OFF_TABLE_BASE = 8'h04; // rx_descriptor_table_base
   localparam logic [7:0] OFF_TABLE_END = 8'h08; // last descriptor index
   localparam logic [7:0] OFF_DESC_PTR = 8'h0C; // rx_descriptor_pointer
   localparam logic [7:0] OFF_CONTROL = 8'h10; // receiver enable
   localparam logic [7:0] OFF_TIMING = 8'h14; // parallel_port_timing_reg
   localparam logic [7:0] OFF_REJ_CHAR = 8'h18; // rejected_ctrl_char_reg
   localparam logic [7:0] OFF_EVENT = 8'h1C; // sticky events, read clears
   localparam logic [7:0] OFF_MASK = 8'h20; // event mask
   localparam logic [7:0] OFF_CHAR_TABLE = 8'h40; // eight entries, step 4

   // ************************************************************
   // field layout
   // ************************************************************
   localparam int FC_LSB = 0; // function code bits 3..0
   localparam int FC_WIDTH = 4;
   localparam int ORDER_BIT = 4; // byte_order_select
   localparam int ENTRY_VALID_BIT = 15; // control char entry valid
   localparam int ENTRY_REJECT_BIT = 14; // control char entry reject
   localparam int CHAR_COUNT = 8; // table depth
   localparam int EV_REJECT = 0; // rejected control char event
   localparam int EV_CLOSE = 1; // buffer closed event
   localparam int EV_ERROR = 2; // receive error event
   localparam int EV_WIDTH = 3;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] RST_FUNC_CODE = 8'h18; // fc 1000, big endian
   localparam logic [15:0] RST_TABLE_BASE = 16'h0000;
   localparam logic [15:0] RST_TABLE_END = 16'h0007;
   localparam logic [15:0] RST_TIMING = 16'h0101;
   localparam logic [EV_WIDTH-1:0] RST_MASK = 3'h0;

   // descriptor status codes written on buffer close
   localparam logic [1:0] STAT_NORMAL = 2'h0;
   localparam logic [1:0] STAT_CTRL = 2'h1;
   localparam logic [1:0] STAT_OVERRUN = 2'h2;
endpackage
`default_nettype wire

// >>> design/char_matcher.sv
// control character table matcher, one compare per entry
`default_nettype none
module char_matcher (
   input wire logic [8*16-1:0] entries,
   input wire logic [7:0] rxChar,
   output logic hit,
   output logic reject
);
   logic [7:0] hits; // per entry match
   logic [7:0] rejs; // per entry reject flag

   // ************************************************************
   // compare logic
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gEntry
         // invalid entries never match
         assign hits[g] = entries[16*g+15] && (entries[16*g +: 8] == rxChar); // RULE_16
         assign rejs[g] = hits[g] && entries[16*g+14]; // RULE_13
      end
   endgenerate

   assign hit = |hits; // RULE_10
   assign reject = |rejs;
endmodule
`default_nettype wire

// >>> design/pp_rx_ctrl.sv
// parallel port receive buffer control: dma words, descriptors, control chars
//
// Strobed register access and the register addresses were chosen for this implementation.
`default_nettype none

// Notes on behaviour
// (RULE_01) function code driven on every dma access
// (RULE_02) software never programs code 0111
// (RULE_03) order bit one: earlier byte in msb
// (RULE_04) order bit zero: bytes reversed in word
// (RULE_05) software writes zero to reserved bits
// (RULE_06) pointer: next when idle, current in frame
// (RULE_07) reload pointer from base, reset or end
// (RULE_08) software writes pointer only while disabled
// (RULE_09) software initialises its parameters before enable
// (RULE_10) compare against up to eight control chars
// (RULE_11) accepted char stored, buffer closed, next opened
// (RULE_12) rejected char to register, maskable interrupt
// (RULE_13) table entry: char, valid bit, reject bit
// (RULE_14) errors reported in descriptor status
// (RULE_15) timing register sets ack width and delay
// (RULE_16) invalid entries ignored, misses are data
module pp_rx_ctrl (
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   output logic irq,
   // received byte stream, same clock
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic rxEnd,
   input wire logic rxError,
   // dma word write out
   output logic dmaWrite,
   output logic [15:0] dmaData,
   output logic [3:0] dmaFuncCode,
   // descriptor close
   output logic descClose,
   output logic [15:0] descIndex,
   output logic [1:0] descStatus,
   // handshake timing settings
   output logic [7:0] ackWidth,
   output logic [7:0] ackBusyDelay
);
   // ************************************************************
   // state
   // ************************************************************
   typedef enum logic [1:0] {IDLE, FRAME} rxState_t;

   typedef struct packed {
      rxState_t state; // receiver phase
      logic enable; // receiver enable
      logic [7:0] funcByte; // dma_function_code_byte
      logic [15:0] tableBase; // rx_descriptor_table_base
      logic [15:0] tableEnd; // last descriptor index
      logic [15:0] descPtr; // rx_descriptor_pointer
      logic [15:0] timing; // parallel_port_timing_reg
      logic [7:0] rejChar; // rejected_ctrl_char_reg
      logic [2:0] events; // sticky status
      logic [2:0] mask; // interrupt mask
      logic [8*16-1:0] chars; // control character table
      logic half; // one byte held in word
      logic [7:0] firstByte; // earlier byte of word
      logic [15:0] rdData;
      logic irq;
      logic dmaWrite;
      logic [15:0] dmaData;
      logic descClose;
      logic [15:0] descIndex;
      logic [1:0] descStatus;
   } regs_t;

   regs_t r;
   regs_t next_r;
   logic charHit; // byte matches a valid entry
   logic charRej; // matching entry rejects

   char_matcher uMatch (
      .entries(r.chars),
      .rxChar(rxByte),
      .hit(charHit),
      .reject(charRej)
   );

   // packs two bytes in the configured byte order
   function automatic logic [15:0] packWord(input logic order, input logic [7:0] early,
                                            input logic [7:0] late);
      logic [15:0] w;
      w = order ? {early, late} : {late, early}; // RULE_03 RULE_04
      return w;
   endfunction

   // ************************************************************
   // next state logic
   // ************************************************************
   always_comb begin
      logic [15:0] wordOut; // assembled dma word
      logic doClose; // buffer close this cycle
      logic [2:0] setEv; // events raised this cycle
      wordOut = 16'h0000;
      doClose = 1'b0;
      setEv = 3'h0;
      next_r = r;
      next_r.dmaWrite = 1'b0;
      next_r.descClose = 1'b0;
      next_r.rdData = 16'h0000;

      // receive path, only while enabled
      if (r.enable && rxValid) begin
         next_r.state = FRAME;
         if (charHit && charRej) begin
            // rejected char stays out of the buffer
            next_r.rejChar = rxByte; // RULE_12
            setEv[pp_rx_pkg::EV_REJECT] = 1'b1; // RULE_12
         end else begin
            // data and accepted control chars both go to the buffer
            if (r.half) begin
               wordOut = packWord(r.funcByte[pp_rx_pkg::ORDER_BIT], r.firstByte, rxByte);
               next_r.half = 1'b0;
            end else begin
               wordOut = packWord(r.funcByte[pp_rx_pkg::ORDER_BIT], rxByte, 8'h00);
               next_r.half = 1'b1;
               next_r.firstByte = rxByte;
            end
            // a word goes out when full, or partial on close
            if (r.half || charHit || rxEnd) begin
               next_r.dmaWrite = 1'b1;
               next_r.dmaData = wordOut;
               next_r.half = 1'b0;
            end
            if (charHit) begin
               doClose = 1'b1; // RULE_11
               next_r.descStatus = pp_rx_pkg::STAT_CTRL;
            end
         end
         if (rxEnd && !doClose) begin
            doClose = 1'b1;
            next_r.descStatus = pp_rx_pkg::STAT_NORMAL;
         end
      end
      // error closes the buffer with status
      if (r.enable && rxError) begin
         doClose = 1'b1;
         next_r.descStatus = pp_rx_pkg::STAT_OVERRUN; // RULE_14
         setEv[pp_rx_pkg::EV_ERROR] = 1'b1;
         if (r.half && !next_r.dmaWrite) begin
            next_r.dmaWrite = 1'b1;
            next_r.dmaData = packWord(r.funcByte[pp_rx_pkg::ORDER_BIT], r.firstByte, 8'h00);
         end
         next_r.half = 1'b0;
      end

      // descriptor pointer holds current during frame, advances on close
      if (doClose) begin
         next_r.descClose = 1'b1;
         next_r.descIndex = r.descPtr; // RULE_06
         next_r.state = IDLE;
         setEv[pp_rx_pkg::EV_CLOSE] = 1'b1;
         if (r.descPtr >= r.tableEnd) begin
            next_r.descPtr = r.tableBase; // RULE_07
         end else begin
            next_r.descPtr = r.descPtr + 16'h0001; // RULE_06
         end
      end

      // register writes
      if (regWrite) begin
         if (regAddr == pp_rx_pkg::OFF_FUNC_CODE) begin
            next_r.funcByte = {3'h0, regWrData[4:0]}; // reserved bits forced zero
         end else if (regAddr == pp_rx_pkg::OFF_TABLE_BASE) begin
            next_r.tableBase = regWrData;
         end else if (regAddr == pp_rx_pkg::OFF_TABLE_END) begin
            next_r.tableEnd = regWrData;
         end else if (regAddr == pp_rx_pkg::OFF_DESC_PTR) begin
            // ignored while running, keeps the frame pointer sane
            if (!r.enable) begin
               next_r.descPtr = regWrData; // RULE_08
            end
         end else if (regAddr == pp_rx_pkg::OFF_CONTROL) begin
            next_r.enable = regWrData[0];
            if (!regWrData[0]) begin
               next_r.state = IDLE;
               next_r.half = 1'b0;
            end
         end else if (regAddr == pp_rx_pkg::OFF_TIMING) begin
            next_r.timing = regWrData; // RULE_15
         end else if (regAddr == pp_rx_pkg::OFF_MASK) begin
            next_r.mask = regWrData[2:0];
         end else if (regAddr[7:5] == pp_rx_pkg::OFF_CHAR_TABLE[7:5]) begin
            next_r.chars[16*regAddr[4:2] +: 16] = regWrData; // RULE_13
         end
      end

      // register reads, unmapped read as zero
      if (regRead) begin
         if (regAddr == pp_rx_pkg::OFF_FUNC_CODE) begin
            next_r.rdData = {8'h00, r.funcByte};
         end else if (regAddr == pp_rx_pkg::OFF_TABLE_BASE) begin
            next_r.rdData = r.tableBase;
         end else if (regAddr == pp_rx_pkg::OFF_TABLE_END) begin
            next_r.rdData = r.tableEnd;
         end else if (regAddr == pp_rx_pkg::OFF_DESC_PTR) begin
            next_r.rdData = r.descPtr;
         end else if (regAddr == pp_rx_pkg::OFF_CONTROL) begin
            next_r.rdData = {14'h0000, (r.state == FRAME), r.enable};
         end else if (regAddr == pp_rx_pkg::OFF_TIMING) begin
            next_r.rdData = r.timing;
         end else if (regAddr == pp_rx_pkg::OFF_REJ_CHAR) begin
            next_r.rdData = {8'h00, r.rejChar};
         end else if (regAddr == pp_rx_pkg::OFF_EVENT) begin
            next_r.rdData = {13'h0000, r.events};
            next_r.events = 3'h0; // read clears
         end else if (regAddr == pp_rx_pkg::OFF_MASK) begin
            next_r.rdData = {13'h0000, r.mask};
         end else if (regAddr[7:5] == pp_rx_pkg::OFF_CHAR_TABLE[7:5]) begin
            next_r.rdData = r.chars[16*regAddr[4:2] +: 16];
         end
      end

      // new events win over read clear
      next_r.events = next_r.events | setEv;
      next_r.irq = |(next_r.events & next_r.mask); // RULE_12
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r <= '0;
         r.state <= IDLE;
         r.funcByte <= pp_rx_pkg::RST_FUNC_CODE;
         r.tableBase <= pp_rx_pkg::RST_TABLE_BASE;
         r.tableEnd <= pp_rx_pkg::RST_TABLE_END;
         r.descPtr <= pp_rx_pkg::RST_TABLE_BASE; // RULE_07
         r.timing <= pp_rx_pkg::RST_TIMING;
         r.mask <= pp_rx_pkg::RST_MASK;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flip-flops
   assign regRdData = r.rdData;
   assign irq = r.irq;
   assign dmaWrite = r.dmaWrite;
   assign dmaData = r.dmaData;
   assign dmaFuncCode = r.funcByte[pp_rx_pkg::FC_LSB +: pp_rx_pkg::FC_WIDTH]; // RULE_01
   assign descClose = r.descClose;
   assign descIndex = r.descIndex;
   assign descStatus = r.descStatus;
   assign ackWidth = r.timing[7:0]; // RULE_15
   assign ackBusyDelay = r.timing[15:8]; // RULE_15

   // ************************************************************
   // checks
   // ************************************************************
   chk_reject_raises_irq: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
      (r.enable && rxValid && charHit && charRej && r.mask[0] && !regWrite)
      |=> (irq && r.rejChar == $past(rxByte)))
      else $error("rejected char did not raise interrupt");

   chk_reject_no_store: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
      (r.enable && rxValid && charHit && charRej && !rxError) |=> !dmaWrite)
      else $error("rejected char written to buffer");

   chk_accept_closes: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
      (r.enable && rxValid && charHit && !charRej) |=> (descClose && dmaWrite))
      else $error("accepted char did not close buffer");

   chk_ptr_wraps: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
      (r.enable && ((rxEnd && rxValid) || rxError) && r.descPtr >= r.tableEnd && !regWrite)
      |=> (r.descPtr == $past(r.tableBase)))
      else $error("pointer did not wrap to base");

   chk_ptr_held_frame: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
      (r.state == FRAME && !descClose && !regWrite) ##1 (r.state == FRAME && !descClose)
      |-> $stable(r.descPtr))
      else $error("pointer moved inside frame");

   chk_ptr_write_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
      (regWrite && regAddr == pp_rx_pkg::OFF_DESC_PTR && r.enable && !rxValid && !rxError)
      |=> $stable(r.descPtr))
      else $error("pointer written while enabled");

   chk_big_endian: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
      (dmaWrite && $past(r.half) && $past(r.funcByte[4]) && $past(rxValid) && !$past(charRej))
      |-> dmaData[7:0] == $past(rxByte))
      else $error("big endian order wrong");

   chk_little_endian: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
      (dmaWrite && $past(r.half) && !$past(r.funcByte[4]) && $past(rxValid) && !$past(charRej))
      |-> dmaData[15:8] == $past(rxByte))
      else $error("little endian order wrong");

   chk_error_status: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_14
      (r.enable && rxError) |=> (descClose && descStatus == pp_rx_pkg::STAT_OVERRUN))
      else $error("error not reported in descriptor");

   chk_func_code: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
      (regWrite && regAddr == pp_rx_pkg::OFF_FUNC_CODE)
      |=> (dmaFuncCode == $past(regWrData[3:0])))
      else $error("function code not presented");

   // nothing may reach the interrupt pin while every event is masked
   chk_irq_masked: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
      (r.mask == 3'h0 && !regWrite)
      |=> !irq)
      else $error("masked event raised interrupt");

   // a status read empties the sticky bits when no new event lands with it
   chk_event_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
      (regRead && regAddr == pp_rx_pkg::OFF_EVENT && !(r.enable && (rxValid || rxError)))
      |=> (r.events == 3'h0))
      else $error("event read did not clear");

   // a normal close below the table end moves on by exactly one descriptor
   chk_ptr_advances: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
      (r.enable && rxValid && rxEnd && r.descPtr < r.tableEnd && !regWrite)
      |=> (r.descPtr == $past(r.descPtr) + 16'h0001))
      else $error("pointer did not advance after close");

   // a byte missing every valid entry is packed like plain data
   chk_miss_is_data: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_16
      (r.enable && rxValid && !charHit && !rxError)
      |=> (dmaWrite == ($past(r.half) || $past(rxEnd))))
      else $error("unmatched byte not handled as data");

   // an accepted control char marks the closed descriptor as such
   chk_ctrl_status: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
      (r.enable && rxValid && charHit && !charRej && !rxError)
      |=> (descStatus == pp_rx_pkg::STAT_CTRL))
      else $error("accepted char status wrong");

   // handshake settings follow the timing register one cycle after a write
   chk_timing_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_15
      (regWrite && regAddr == pp_rx_pkg::OFF_TIMING)
      |=> ({ackBusyDelay, ackWidth} == $past(regWrData)))
      else $error("timing settings not applied");
endmodule
`default_nettype wire

// >>> tb/parallel_host.sv
// behavioural host that pushes bytes and error pulses into the receiver
`default_nettype none
module parallel_host (
   input wire logic clk_sys,
   output logic rxValid,
   output logic [7:0] rxByte,
   output logic rxEnd,
   output logic rxError
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // idle state at time zero
   // ************************************************************
   initial begin
      rxValid = 1'b0;
      rxByte = 8'h00;
      rxEnd = 1'b0;
      rxError = 1'b0;
   end
   // one byte strobe; afterwards the data lines show the inverse so a
   // stale value can never pass for fresh data
   task send(input logic [7:0] b, input logic last);
      @(posedge clk_sys);
      rxValid <= 1'b1;
      rxByte <= b;
      rxEnd <= last;
      @(posedge clk_sys);
      rxValid <= 1'b0;
      rxEnd <= 1'b0;
      rxByte <= ~b;
   endtask
   // one cycle error pulse
   task send_error();
      @(posedge clk_sys);
      rxError <= 1'b1;
      @(posedge clk_sys);
      rxError <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the parallel port receive buffer control
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0; // 40 MHz system clock
   logic rst_n = 1'b0; // synchronous, active low
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdData, dmaData, descIndex;
   logic irq, dmaWrite, descClose, rxValid, rxEnd, rxError;
   logic [7:0] rxByte, ackWidth, ackBusyDelay;
   logic [3:0] dmaFuncCode, lastFc;
   logic [1:0] descStatus, lastStat;
   logic [15:0] lastDma, lastIdx;
   int nDma = 0; // dma words seen
   int nClose = 0; // buffer closes seen
   int n_fail = 0;
   int checked = 0;
   always #12.5 clk_sys = ~clk_sys;
   pp_rx_ctrl i_pp_rx_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .irq(irq), .rxValid(rxValid), .rxByte(rxByte),
      .rxEnd(rxEnd), .rxError(rxError), .dmaWrite(dmaWrite), .dmaData(dmaData),
      .dmaFuncCode(dmaFuncCode), .descClose(descClose), .descIndex(descIndex),
      .descStatus(descStatus), .ackWidth(ackWidth), .ackBusyDelay(ackBusyDelay));
   parallel_host i_parallel_host (.clk_sys(clk_sys), .rxValid(rxValid), .rxByte(rxByte),
      .rxEnd(rxEnd), .rxError(rxError));
   // ************************************************************
   // monitor: pulses stand one cycle, so catch them at the edge
   // ************************************************************
   always @(posedge clk_sys) begin
      if (dmaWrite === 1'b1) begin
         nDma <= nDma + 1;
         lastDma <= dmaData;
         lastFc <= dmaFuncCode;
      end
      if (descClose === 1'b1) begin
         nClose <= nClose + 1;
         lastIdx <= descIndex;
         lastStat <= descStatus;
      end
   end
   // ************************************************************
   // shared helpers
   // ************************************************************
   task final_report();
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      chk(what, exp, regRdData);
   endtask
   // bounded wait on a monitor count; a stall ends the run
   task wait_for(input int target, input bit onClose);
      for (int k = 0; k < 20; k++) begin
         if ((onClose ? nClose : nDma) >= target) return;
         @(posedge clk_sys);
         #1;
      end
      $display("wrong value wait count expected %0d seen %0d", target,
               (onClose ? nClose : nDma));
      n_fail++;
      final_report();
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task sc_reset_timing();
      rd_chk("fc byte", pp_rx_pkg::OFF_FUNC_CODE, 16'h0018);
      rd_chk("desc ptr", pp_rx_pkg::OFF_DESC_PTR, 16'h0000);
      rd_chk("timing", pp_rx_pkg::OFF_TIMING, 16'h0101);
      rd_chk("unmapped", 8'h3C, 16'h0000);
      wr(pp_rx_pkg::OFF_TIMING, 16'h0305);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("ack width", 16'h0005, {8'h00, ackWidth});
      chk("ack delay", 16'h0003, {8'h00, ackBusyDelay});
   endtask
   task sc_big_endian();
      wr(pp_rx_pkg::OFF_CONTROL, 16'h0001);
      i_parallel_host.send(8'h12, 1'b0);
      i_parallel_host.send(8'h34, 1'b1);
      wait_for(1, 1'b0);
      chk("dma word", 16'h1234, lastDma);
      chk("func code", 16'h0008, {12'h000, lastFc});
      wait_for(1, 1'b1);
      chk("close index", 16'h0000, lastIdx);
      chk("close status", 16'h0000, {14'h0000, lastStat});
      rd_chk("ptr next", pp_rx_pkg::OFF_DESC_PTR, 16'h0001);
      wr(pp_rx_pkg::OFF_DESC_PTR, 16'h0005);
      rd_chk("ptr locked", pp_rx_pkg::OFF_DESC_PTR, 16'h0001);
   endtask
   task sc_ctrl_chars();
      wr(pp_rx_pkg::OFF_CHAR_TABLE, 16'h800D);
      wr(pp_rx_pkg::OFF_CHAR_TABLE + 8'h04, 16'hC01B);
      wr(pp_rx_pkg::OFF_CHAR_TABLE + 8'h08, 16'h0041);
      i_parallel_host.send(8'h0D, 1'b0);
      wait_for(2, 1'b0);
      chk("accepted word", 16'h0D00, lastDma);
      wait_for(2, 1'b1);
      chk("accept status", 16'h0001, {14'h0000, lastStat});
      chk("accept index", 16'h0001, lastIdx);
      i_parallel_host.send(8'h1B, 1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk("reject not stored", 16'h0002, nDma[15:0]);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      rd_chk("rejected char", pp_rx_pkg::OFF_REJ_CHAR, 16'h001B);
      wr(pp_rx_pkg::OFF_MASK, 16'h0001);
      @(posedge clk_sys);
      #1;
      chk("irq raised", 16'h0001, {15'h0000, irq});
      rd_chk("events", pp_rx_pkg::OFF_EVENT, 16'h0003);
      @(posedge clk_sys);
      #1;
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      // second reject, now unmasked: the interrupt must follow at once
      i_parallel_host.send(8'h1B, 1'b0);
      @(posedge clk_sys);
      #1;
      chk("irq on reject", 16'h0001, {15'h0000, irq});
      i_parallel_host.send(8'h41, 1'b0);
      i_parallel_host.send(8'h42, 1'b1);
      wait_for(3, 1'b0);
      chk("plain word", 16'h4142, lastDma);
      rd_chk("ptr after", pp_rx_pkg::OFF_DESC_PTR, 16'h0003);
   endtask
   task sc_error_wrap();
      wr(pp_rx_pkg::OFF_CONTROL, 16'h0000);
      wr(pp_rx_pkg::OFF_TABLE_END, 16'h0003);
      wr(pp_rx_pkg::OFF_CONTROL, 16'h0001);
      i_parallel_host.send(8'h55, 1'b0);
      i_parallel_host.send_error();
      wait_for(4, 1'b1);
      chk("error status", 16'h0002, {14'h0000, lastStat});
      chk("error index", 16'h0003, lastIdx);
      chk("flushed word", 16'h5500, lastDma);
      rd_chk("ptr wrapped", pp_rx_pkg::OFF_DESC_PTR, 16'h0000);
   endtask
   task sc_little_endian();
      wr(pp_rx_pkg::OFF_CONTROL, 16'h0000);
      wr(pp_rx_pkg::OFF_FUNC_CODE, 16'h0009);
      wr(pp_rx_pkg::OFF_CONTROL, 16'h0001);
      i_parallel_host.send(8'h56, 1'b0);
      i_parallel_host.send(8'h78, 1'b1);
      wait_for(nDma + 1, 1'b0);
      chk("swapped word", 16'h7856, lastDma);
      chk("new func code", 16'h0009, {12'h000, lastFc});
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      sc_reset_timing();
      sc_big_endian();
      sc_ctrl_chars();
      sc_error_wrap();
      sc_little_endian();
      final_report();
   end
endmodule
`default_nettype wire
